//--- pkg/jtp_pkg.sv
// constants and types shared by the boundary-scan test port
package jtp_pkg;

    localparam int IR_W   = 8;
    localparam int ID_W   = 32;
    localparam int BSR_W  = 113;
    localparam int SYNC_W = BSR_W + 4;

    // instruction codes; values below are a free assignment for this block
    localparam logic [IR_W-1:0] INS_EXTEST = 8'h00;
    localparam logic [IR_W-1:0] INS_IDCODE = 8'h01;
    localparam logic [IR_W-1:0] INS_SAMPLE = 8'h05;
    localparam logic [IR_W-1:0] INS_HIGHZ  = 8'h03;
    localparam logic [IR_W-1:0] INS_CLAMP  = 8'h07;
    localparam logic [IR_W-1:0] INS_BYPASS = 8'hFF;

    localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;

    // identification value is arbitrary; bit 0 set as scan chains expect
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_A001;

    // position of the impedance calibration pin inside the boundary register
    localparam int ZQ_BIT = 0;

    localparam int BUF_DEPTH = 2;
    localparam int BUF_W     = 2;

    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h2,
        ST_CAP_DR     = 4'h3,
        ST_SHIFT_DR   = 4'h4,
        ST_EXIT1_DR   = 4'h5,
        ST_PAUSE_DR   = 4'h6,
        ST_EXIT2_DR   = 4'h7,
        ST_UPD_DR     = 4'h8,
        ST_SEL_IR     = 4'h9,
        ST_CAP_IR     = 4'hA,
        ST_SHIFT_IR   = 4'hB,
        ST_EXIT1_IR   = 4'hC,
        ST_PAUSE_IR   = 4'hD,
        ST_EXIT2_IR   = 4'hE,
        ST_UPD_IR     = 4'hF
    } jtp_state_t;

    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_ID     = 2'h1,
        SEL_BSR    = 2'h2
    } jtp_sel_t;

endpackage

//--- pkg/jtp_stream_if.sv
// valid/ready stream carrying the serial output bit and its enable
`timescale 1ns/1ps
interface jtp_stream_if;
    import jtp_pkg::*;
    logic               valid;
    logic               ready;
    logic [BUF_W-1:0]   data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- rtl/jtp_sync.sv
// two flip-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/1ps
module jtp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- rtl/jtp_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
module jtp_buf2
    import jtp_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    jtp_stream_if.snk   wr,
    jtp_stream_if.src   rd
);
    logic [BUF_W-1:0] mem_q [BUF_DEPTH];
    logic             wp_q;
    logic             rp_q;
    logic [1:0]       cnt_q;
    logic             push;
    logic             pop;

    assign wr.ready = (cnt_q != 2'h2);
    assign rd.valid = (cnt_q != 2'h0);
    assign rd.data  = mem_q[rp_q];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
        end else begin
            if (push) begin
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 2'h0;
        end else if (push && !pop) begin
            cnt_q <= cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end
endmodule

//--- rtl/jtp_tap.sv
// boundary-scan test access port, oversampling the test clock
`timescale 1ns/1ps
// Notes on behaviour
// - sample on test clock rise, drive on fall
// - state advances per rise by sampled mode-select
// - five high mode-select rises reach reset
// - idle holds while mode-select low
// - select-data state leaves registers untouched
// - capture-data loads selected register in parallel
// - shift-data moves one bit per clock
// - exit, pause and resume paths for data
// - external test outputs change at update only
// - eight-bit instruction, active after update
// - identify instruction after power-up and reset
// - capture-instruction loads binary 01 in LSBs
// - output enabled only in shift states
// - enter at MSB, leave from LSB
// - instruction picks exactly one register
// - one-bit bypass cleared when executed
// - 113-bit boundary register captures and shifts
// - capture loads fixed 32-bit identity value
// - port reset leaves memory operation alone
// - power-up reset leaves output high-impedance
// - impedance mode bit low during pin scan
// - snapshot instruction captures all pin levels
// - high-z instruction selects boundary, floats outputs
// - clamp drives boundary values onto outputs
module jtp_tap
    import jtp_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo_o,
    output logic                  tdo_oe,
    input  wire logic [BSR_W-1:0] pin_in,
    input  wire logic             impedance_select_mode_bit,
    output logic      [BSR_W-1:0] pin_out,
    output logic                  pin_drive_scan,
    output logic                  pin_hiz,
    output logic                  test_logic_reset
);
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;
    logic              tck_s;
    logic              tms_s;
    logic              tdi_s;
    logic              mode_bit_s;
    logic [BSR_W-1:0]  pin_s;
    logic              tck_prev_q;
    logic              tck_rise;
    logic              tck_fall;
    logic              rise_pend_q;
    logic              tms_lat_q;
    logic              tdi_lat_q;
    logic              step;
    logic              push_pend_q;

    jtp_state_t        state_q;
    jtp_state_t        state_d;
    logic [IR_W-1:0]   ir_shift_q;
    logic [IR_W-1:0]   ir_q;
    logic              bypass_q;
    logic [ID_W-1:0]   id_q;
    logic [BSR_W-1:0]  bsr_q;
    logic [BSR_W-1:0]  bsr_upd_q;
    logic [BSR_W-1:0]  pin_cap;
    jtp_sel_t          sel;
    logic              out_bit;
    logic              out_en;

    jtp_stream_if      fill ();
    jtp_stream_if      drain ();

    assign raw_in = {tck, tms, tdi, impedance_select_mode_bit, pin_in};

    // every pin is foreign to clk, so all pass the same two-stage bank
    jtp_sync #(
        .W        (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    assign tck_s      = sync_in[SYNC_W-1];
    assign tms_s      = sync_in[SYNC_W-2];
    assign tdi_s      = sync_in[SYNC_W-3];
    assign mode_bit_s = sync_in[SYNC_W-4];
    assign pin_s      = sync_in[BSR_W-1:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
        end
    end

    // edge finding on the synchronised copy; a tied-low clock never steps
    assign tck_rise = tck_s && !tck_prev_q;
    assign tck_fall = !tck_s && tck_prev_q;

    // inputs are taken at the rising edge and held until the step runs
    always_ff @(posedge clk) begin
        if (rst) begin
            rise_pend_q <= 1'b0;
            tms_lat_q   <= 1'b1;
            tdi_lat_q   <= 1'b1;
        end else begin
            if (tck_rise) begin
                rise_pend_q <= 1'b1;
                tms_lat_q   <= tms_s;
                tdi_lat_q   <= tdi_s;
            end else if (step) begin
                rise_pend_q <= 1'b0;
            end
        end
    end

    // a full output buffer holds the step back so no output bit is lost
    assign step = rise_pend_q && !push_pend_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET:    state_d = tms_lat_q ? ST_RESET : ST_IDLE;
            ST_IDLE:     state_d = tms_lat_q ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR:   state_d = tms_lat_q ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR:   state_d = tms_lat_q ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms_lat_q ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms_lat_q ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms_lat_q ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms_lat_q ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR:   state_d = tms_lat_q ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR:   state_d = tms_lat_q ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR:   state_d = tms_lat_q ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms_lat_q ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms_lat_q ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms_lat_q ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms_lat_q ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR:   state_d = tms_lat_q ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // power-up reset enters the reset state; memory core is never touched
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_RESET;
        end else if (step) begin
            state_q <= state_d;
        end
    end

    assign test_logic_reset = (state_q == ST_RESET);

    // instruction path
    always_ff @(posedge clk) begin
        if (rst) begin
            ir_shift_q <= INS_IDCODE;
        end else if (step) begin
            unique case (state_q)
                ST_CAP_IR:   ir_shift_q <= {ir_shift_q[IR_W-1:2], IR_CAPTURE_LSB};
                ST_SHIFT_IR: ir_shift_q <= {tdi_lat_q, ir_shift_q[IR_W-1:1]};
                default:     ir_shift_q <= ir_shift_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ir_q <= INS_IDCODE;
        end else if (step) begin
            if (state_d == ST_RESET) begin
                ir_q <= INS_IDCODE;
            end else if (state_q == ST_UPD_IR) begin
                ir_q <= ir_shift_q;
            end
        end
    end

    // one register is chosen per instruction; clamp keeps the short path
    always_comb begin
        unique case (ir_q)
            INS_IDCODE: sel = SEL_ID;
            INS_EXTEST: sel = SEL_BSR;
            INS_SAMPLE: sel = SEL_BSR;
            INS_HIGHZ:  sel = SEL_BSR;
            default:    sel = SEL_BYPASS;
        endcase
    end

    // the impedance pin only reads true while its mode bit is low
    always_comb begin
        pin_cap         = pin_s;
        pin_cap[ZQ_BIT] = pin_s[ZQ_BIT] & ~mode_bit_s;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bypass_q <= 1'b0;
        end else if (step && sel == SEL_BYPASS) begin
            unique case (state_q)
                ST_CAP_DR:   bypass_q <= 1'b0;
                ST_SHIFT_DR: bypass_q <= tdi_lat_q;
                default:     bypass_q <= bypass_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            id_q <= ID_VALUE;
        end else if (step && sel == SEL_ID) begin
            unique case (state_q)
                ST_CAP_DR:   id_q <= ID_VALUE;
                ST_SHIFT_DR: id_q <= {tdi_lat_q, id_q[ID_W-1:1]};
                default:     id_q <= id_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bsr_q <= '0;
        end else if (step && sel == SEL_BSR) begin
            unique case (state_q)
                ST_CAP_DR:   bsr_q <= pin_cap;
                ST_SHIFT_DR: bsr_q <= {tdi_lat_q, bsr_q[BSR_W-1:1]};
                default:     bsr_q <= bsr_q;
            endcase
        end
    end

    // parallel outputs move only at update, never while shifting
    always_ff @(posedge clk) begin
        if (rst) begin
            bsr_upd_q <= '0;
        end else if (step && state_q == ST_UPD_DR && sel == SEL_BSR) begin
            bsr_upd_q <= bsr_q;
        end
    end

    assign pin_out        = bsr_upd_q;
    assign pin_drive_scan = (ir_q == INS_EXTEST) || (ir_q == INS_CLAMP);
    assign pin_hiz        = (ir_q == INS_HIGHZ);

    // bit that will leave on the next falling edge
    always_comb begin
        if (state_q == ST_SHIFT_IR) begin
            out_bit = ir_shift_q[0];
        end else begin
            unique case (sel)
                SEL_ID:  out_bit = id_q[0];
                SEL_BSR: out_bit = bsr_q[0];
                default: out_bit = bypass_q;
            endcase
        end
    end

    assign out_en = (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);

    // after each step the new output level is queued for the falling edge
    always_ff @(posedge clk) begin
        if (rst) begin
            push_pend_q <= 1'b0;
        end else if (step) begin
            push_pend_q <= 1'b1;
        end else if (fill.ready) begin
            push_pend_q <= 1'b0;
        end
    end

    assign fill.valid = push_pend_q;
    assign fill.data  = {out_en, out_bit};

    jtp_buf2 u_buf (
        .clk (clk),
        .rst (rst),
        .wr  (fill),
        .rd  (drain)
    );

    // the output stage only takes a word on a falling edge
    assign drain.ready = tck_fall;

    always_ff @(posedge clk) begin
        if (rst) begin
            tdo_o  <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (drain.valid && drain.ready) begin
            tdo_o  <= drain.data[0];
            tdo_oe <= drain.data[1];
        end
    end

endmodule

//--- bench/jtp_tap_monitor.sv
// concurrent checks on the boundary-scan port pins
`timescale 1ns/1ps
module jtp_tap_monitor
    import jtp_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             tck,
    input wire logic             tms,
    input wire logic             tdi,
    input wire logic             tdo_o,
    input wire logic             tdo_oe,
    input wire logic [BSR_W-1:0] pin_in,
    input wire logic             impedance_select_mode_bit,
    input wire logic [BSR_W-1:0] pin_out,
    input wire logic             pin_drive_scan,
    input wire logic             pin_hiz,
    input wire logic             test_logic_reset
);
    logic       tck_q;
    logic       tms_rise_q;
    logic [3:0] fall_cnt_q;
    logic [3:0] rise_cnt_q;
    logic [2:0] ones_q;
    wire logic  rise_w = tck & ~tck_q;
    wire logic  fall_w = ~tck & tck_q;

    always_ff @(posedge clk) begin
        tck_q <= tck;
    end
    // counters saturate so a test clock standing still cannot wrap them
    always_ff @(posedge clk) begin
        if (rst) begin
            fall_cnt_q <= 4'hF;
        end else if (fall_w) begin
            fall_cnt_q <= 4'h0;
        end else if (fall_cnt_q != 4'hF) begin
            fall_cnt_q <= fall_cnt_q + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rise_cnt_q <= 4'hF;
            ones_q     <= 3'h0;
            tms_rise_q <= 1'b1;
        end else if (rise_w) begin
            rise_cnt_q <= 4'h0;
            ones_q     <= !tms ? 3'h0 : (ones_q == 3'h7) ? 3'h7 : ones_q + 3'h1;
            tms_rise_q <= tms;
        end else if (rise_cnt_q != 4'hF) begin
            rise_cnt_q <= rise_cnt_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_high_rise;
        rise_w && tms;
    endsequence
    sequence s_fifth_high;
        s_high_rise ##0 ones_q >= 3'h4;
    endsequence

    a_tdo_after_fall: assert property ($changed({tdo_o, tdo_oe}) |-> fall_cnt_q inside {[1:6]})
        else $error("tdo moved away from a test clock fall");
    a_five_ones_reset: assert property (s_fifth_high |-> ##[1:6] test_logic_reset)
        else $error("five high mode rises did not reach reset");
    a_reset_holds_high: assert property (test_logic_reset ##0 s_high_rise |-> ##1 test_logic_reset [*6])
        else $error("reset state left with mode select high");
    a_leave_on_low: assert property ($fell(test_logic_reset) |-> rise_cnt_q inside {[1:6]} && !tms_rise_q)
        else $error("reset state left without a low mode rise");
    a_pins_at_update: assert property ($changed(pin_out) |-> rise_cnt_q inside {[1:6]})
        else $error("pin outputs changed away from a test clock rise");
    a_mode_at_update: assert property ($changed({pin_drive_scan, pin_hiz}) |-> rise_cnt_q inside {[1:6]})
        else $error("instruction outputs changed away from a rise");
    a_oe_off_reset: assert property (test_logic_reset |-> !tdo_oe)
        else $error("tdo driven in reset state");
    a_power_up_state: assert property ($fell(rst) |-> test_logic_reset && !tdo_oe && !pin_hiz && !pin_drive_scan && pin_out == '0)
        else $error("wrong state after power-up reset");
    a_one_mode: assert property (!(pin_hiz && pin_drive_scan))
        else $error("float and drive modes at once");
    a_quiet_in_reset: assert property ($past(test_logic_reset) && test_logic_reset |-> !pin_drive_scan && !pin_hiz && $stable(pin_out))
        else $error("test logic active in reset state");
endmodule

bind jtp_tap jtp_tap_monitor u_mon (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .impedance_select_mode_bit(impedance_select_mode_bit),
    .pin_out(pin_out), .pin_drive_scan(pin_drive_scan), .pin_hiz(pin_hiz),
    .test_logic_reset(test_logic_reset)
);

//--- bench/jtp_ctl_model.sv
// behavioural board test controller driving the scan pins
`timescale 1ns/1ps
module jtp_ctl_model (
    input  wire logic clk,
    input  wire logic tdo_o,
    input  wire logic tdo_oe,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    // memory taken as initialised before any scan
    // lines rest at their pull-up level; test clock stands still between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one test clock period; tdo read late in the high phase, well after it settled
    task automatic step(input logic m, input logic dbit, output logic o, output logic oe);
        tms <= m;
        tdi <= dbit;
        repeat (4) @(posedge clk);
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        // a released line has no pull, so show the opposite of the last level
        o  = tdo_oe ? tdo_o : ~tdo_o;
        oe = tdo_oe;
        tck <= 1'b0;
    endtask
endmodule

//--- bench/jtp_tap_tb.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module jtp_tap_tb
    import jtp_pkg::*;
;
    localparam logic [119:0] PAT_A = {15{8'hC5}};
    localparam logic [119:0] PAT_B = {15{8'h3A}};
    localparam logic [119:0] PAT_C = {15{8'h96}};
    logic             clk;
    logic             rst;
    logic             tck;
    logic             tms;
    logic             tdi;
    logic             tdo_o;
    logic             tdo_oe;
    logic [BSR_W-1:0] pin_in;
    logic             mode_bit;
    logic [BSR_W-1:0] pin_out;
    logic             pin_drive_scan;
    logic             pin_hiz;
    logic             test_logic_reset;
    logic [127:0]     d;
    logic             o;
    logic             oe;
    int               fail_count = 0;
    int               checked = 0;
    int               cycles = 0;

    jtp_tap dut (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
        .pin_in(pin_in), .impedance_select_mode_bit(mode_bit), .pin_out(pin_out),
        .pin_drive_scan(pin_drive_scan), .pin_hiz(pin_hiz), .test_logic_reset(test_logic_reset)
    );
    jtp_ctl_model ctl (
        .clk(clk), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi)
    );

    task automatic final_report();
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // full scan from idle back to idle; pz picks a shift bit after which to pause
    task automatic scan(input bit ir, input int n, input logic [127:0] din, input int pz);
        logic [BSR_W-1:0] po;
        po = pin_out;
        d = '0;
        ctl.step(1'b1, 1'b1, o, oe);
        if (ir) ctl.step(1'b1, 1'b1, o, oe);
        ctl.step(1'b0, 1'b1, o, oe);
        ctl.step(1'b0, 1'b1, o, oe);
        for (int i = 0; i < n; i++) begin
            ctl.step(i == n - 1 || i == pz, din[i], o, oe);
            d[i] = o;
            chk("tdo enable", 1, oe);
            if (i == pz) begin
                for (int k = 0; k < 4; k++) begin
                    ctl.step(k == 2, 1'b1, o, oe);
                    chk("pause enable", 0, oe);
                end
            end
        end
        chk("pins in shift", po, pin_out);
        ctl.step(1'b1, 1'b1, o, oe);
        chk("exit enable", 0, oe);
        ctl.step(1'b0, 1'b1, o, oe);
        repeat (4) @(posedge clk);
    endtask
    task automatic load_ir(input logic [IR_W-1:0] code, input int pz);
        scan(1'b1, IR_W, 128'(code), pz);
        chk("ir capture", 2'h1, d[1:0]);
    endtask

    task automatic t_power();
        chk("oe at power-up", 0, tdo_oe);
        chk("reset state", 1, test_logic_reset);
        chk("modes idle", 0, {pin_hiz, pin_drive_scan});
        repeat (3) ctl.step(1'b0, 1'b1, o, oe);
        repeat (2) @(posedge clk);
        chk("idle kept", 0, test_logic_reset);
    endtask
    task automatic t_idcode();
        scan(1'b0, ID_W, '0, -1);
        chk("id value", ID_VALUE, d[ID_W-1:0]);
    endtask
    task automatic t_bypass();
        logic [IR_W-1:0] codes [3] = '{INS_BYPASS, 8'h42, INS_CLAMP};
        for (int k = 0; k < 3; k++) begin
            load_ir(codes[k], k == 0 ? 3 : -1);
            scan(1'b0, 8, 128'h5A, -1);
            chk("bypass path", 128'hB4, d[7:0]);
            chk("clamp drive", k == 2, pin_drive_scan);
        end
    endtask
    task automatic t_sample();
        pin_in <= PAT_A[BSR_W-1:0];
        load_ir(INS_SAMPLE, -1);
        scan(1'b0, BSR_W, PAT_B, 40);
        chk("snapshot", PAT_A[BSR_W-1:0], d[BSR_W-1:0]);
        chk("preload", PAT_B[BSR_W-1:0], pin_out);
    endtask
    task automatic t_extest();
        load_ir(INS_EXTEST, -1);
        chk("extest drive", 1, pin_drive_scan);
        chk("preload kept", PAT_B[BSR_W-1:0], pin_out);
        pin_in <= PAT_C[BSR_W-1:0];
        scan(1'b0, BSR_W, PAT_A, 60);
        chk("capture", PAT_C[BSR_W-1:0], d[BSR_W-1:0]);
        chk("update", PAT_A[BSR_W-1:0], pin_out);
    endtask
    task automatic t_highz();
        // impedance pin testing is over here, so its cell must now read low
        pin_in   <= PAT_A[BSR_W-1:0];
        mode_bit <= 1'b1;
        load_ir(INS_HIGHZ, -1);
        chk("float", 2'h2, {pin_hiz, pin_drive_scan});
        scan(1'b0, BSR_W, PAT_B, -1);
        chk("highz path", {PAT_A[BSR_W-1:1], 1'b0}, d[BSR_W-1:0]);
    endtask
    task automatic t_reset5();
        ctl.step(1'b1, 1'b1, o, oe);
        ctl.step(1'b0, 1'b1, o, oe);
        ctl.step(1'b0, 1'b1, o, oe);
        for (int k = 0; k < 7; k++) begin
            ctl.step(1'b1, 1'b1, o, oe);
            repeat (2) @(posedge clk);
            chk("reset after ones", k >= 4, test_logic_reset);
        end
        chk("instruction reset", 0, pin_hiz);
        ctl.step(1'b0, 1'b1, o, oe);
        repeat (2) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // whole run takes about 4700 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        rst = 1'b1;
        pin_in = '0;
        mode_bit = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_power();
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_highz();
        t_reset5();
        t_idcode();
        final_report();
    end
endmodule
